// ---- logic/ut_fault_handler.sv ----
// Under-temperature fault handler with threshold and action registers.
`timescale 1ns/1ns
module ut_fault_handler
  import ut_fault_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Register access port.
  input wire reg_req_s reg_req,
  output logic reg_ack_r,
  output logic reg_err_r,
  output logic [15:0] reg_rdata_r,
  // Measurement, time unit and control from the controller.
  input wire logic [15:0] temp_meas,
  input wire logic [15:0] delay_unit,
  input wire logic on_cmd,
  input wire logic fault_clear,
  input wire logic other_fault_off,
  // Converter output and status.
  output logic out_en_r,
  output logic fault_flag_r,
  output logic latched_r
);
  logic [15:0] thresh_r;
  logic [7:0] action_r;
  logic fault_r;
  logic below;
  ut_state_e st_r;
  ut_state_e st_nxt;
  logic [2:0] left_r;
  logic [2:0] left_nxt;
  logic [7:0] units_r;
  logic [15:0] ucnt_r;
  logic tmr_done;
  logic tmr_load;
  logic [1:0] resp;
  logic [2:0] retries;
  logic [7:0] dly_units;
  logic [15:0] unit_len;
  logic abort;
  logic retry_ok;

  // Action fields, the decoded delay length and the guarded unit length.
  assign resp = action_r[RESP_HI:RESP_LO];
  assign retries = action_r[RETRY_HI:RETRY_LO];
  assign dly_units = UNITS_ONE << action_r[DLY_HI:DLY_LO];
  assign unit_len = (delay_unit == 16'h0000) ? UNIT_MIN : delay_unit;
  assign abort = !on_cmd || other_fault_off || fault_clear;
  assign retry_ok = (retries == RETRY_FOREVER) || (left_r != 3'h0);

  // The measurement is compared with the threshold as linear-format numbers, not as raw codes.
  linear_less u_cmp (
    .a(temp_meas),
    .b(thresh_r),
    .a_below_b(below)
  );

  // Register writes; the threshold is kept as raw linear code.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      thresh_r <= THRESH_RST;
      action_r <= ACTION_RST;
    end else if (reg_req.wr && reg_req.cmd == CMD_UT_THRESH) begin
      thresh_r <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.cmd == CMD_UT_ACTION) begin
      action_r <= reg_req.wdata[7:0];
    end
  end

  // Register answers one cycle after the request; unknown codes flag an error.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_ack_r <= 1'b0;
      reg_err_r <= 1'b0;
      reg_rdata_r <= RDATA_RST;
    end else begin
      reg_ack_r <= reg_req.wr || reg_req.rd;
      reg_err_r <= (reg_req.wr || reg_req.rd) && reg_req.cmd != CMD_UT_THRESH && reg_req.cmd != CMD_UT_ACTION;
      if (reg_req.rd && reg_req.cmd == CMD_UT_THRESH) begin
        reg_rdata_r <= thresh_r;
      end else if (reg_req.rd && reg_req.cmd == CMD_UT_ACTION) begin
        reg_rdata_r <= {8'h00, action_r};
      end else if (reg_req.rd) begin
        reg_rdata_r <= RDATA_RST;
      end
    end
  end

  // Fault detection and the sticky status bit; a new fault wins over a clear.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_r <= 1'b0;
      fault_flag_r <= 1'b0;
    end else begin
      fault_r <= below;
      if (fault_r) begin
        fault_flag_r <= 1'b1;
      end else if (fault_clear) begin
        fault_flag_r <= 1'b0;
      end
    end
  end

  // Next state and attempt counter of the response sequence.
  always_comb begin
    st_nxt = st_r;
    left_nxt = left_r;
    if (abort) begin
      st_nxt = ST_RUN;
      left_nxt = retries;
    end else begin
      case (st_r)
        ST_RUN: begin
          left_nxt = retries;
          if (fault_r) begin
            case (resp)
              RESP_IGNORE: st_nxt = ST_RUN;
              RESP_CONTINUE: st_nxt = ST_CONT;
              RESP_RETRY: st_nxt = (retries == RETRY_NONE) ? ST_LATCH : ST_OFF_WAIT;
              default: st_nxt = ST_LATCH;
            endcase
          end
        end
        ST_CONT: begin
          if (tmr_done && !fault_r) begin
            st_nxt = ST_RUN;
          end else if (tmr_done) begin
            st_nxt = (retries == RETRY_NONE) ? ST_LATCH : ST_OFF_WAIT;
          end
        end
        ST_OFF_WAIT: begin
          if (tmr_done) begin
            st_nxt = ST_TRY;
            if (retries != RETRY_FOREVER) begin
              left_nxt = left_r - 3'h1;
            end
          end
        end
        ST_TRY: begin
          if (tmr_done && !fault_r) begin
            st_nxt = ST_RUN;
            left_nxt = retries;
          end else if (tmr_done) begin
            st_nxt = retry_ok ? ST_OFF_WAIT : ST_LATCH;
          end
        end
        ST_LATCH: st_nxt = ST_LATCH;
        default: st_nxt = ST_RUN;
      endcase
    end
  end

  // State, output enable and latched indication.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_RUN;
      left_r <= 3'h0;
      out_en_r <= 1'b0;
      latched_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      left_r <= left_nxt;
      out_en_r <= on_cmd && (st_nxt == ST_RUN || st_nxt == ST_CONT || st_nxt == ST_TRY);
      latched_r <= st_nxt == ST_LATCH;
    end
  end

  // Delay timer of whole units; each unit lasts the programmed unit length.
  assign tmr_load = st_nxt != st_r && (st_nxt == ST_CONT || st_nxt == ST_OFF_WAIT || st_nxt == ST_TRY);
  assign tmr_done = units_r == UNITS_ONE && ucnt_r == 16'h0000;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      units_r <= 8'h00;
      ucnt_r <= 16'h0000;
    end else if (tmr_load) begin
      units_r <= dly_units;
      ucnt_r <= unit_len - 16'h0001;
    end else if (units_r != 8'h00 && ucnt_r != 16'h0000) begin
      ucnt_r <= ucnt_r - 16'h0001;
    end else if (units_r != 8'h00) begin
      units_r <= units_r - 8'h01;
      ucnt_r <= unit_len - 16'h0001;
    end
  end

  // Checks run on the system clock and rest while reset is low.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_detect_below: assert property (below |=> fault_r) else $error("Fault not seen below threshold.");
  a_thresh_write: assert property (reg_req.wr && reg_req.cmd == CMD_UT_THRESH
    |=> thresh_r == $past(reg_req.wdata)) else $error("Threshold write lost.");
  a_ignore_runs: assert property (st_r == ST_RUN && resp == RESP_IGNORE && on_cmd && !other_fault_off
    |=> st_r == ST_RUN && out_en_r) else $error("Ignore mode interrupted output.");
  a_cont_enter: assert property (st_r == ST_RUN && fault_r && resp == RESP_CONTINUE && !abort
    |=> st_r == ST_CONT && out_en_r) else $error("Continue mode did not keep running.");
  a_disable_now: assert property (st_r == ST_RUN && fault_r && resp == RESP_RETRY && !abort
    |=> !out_en_r) else $error("Output not disabled at once.");
  a_latch_holds: assert property (st_r == ST_LATCH && !abort
    |=> st_r == ST_LATCH && !out_en_r) else $error("Latched off state left without clear.");
  a_no_retry: assert property (st_r == ST_RUN && fault_r && resp == RESP_RETRY && !abort
    && retries == RETRY_NONE |=> st_r == ST_LATCH) else $error("Restart tried with zero retries.");
  a_retry_spent: assert property (st_r == ST_TRY && tmr_done && fault_r && left_r == 3'h0
    && retries != RETRY_FOREVER && !abort |=> st_r == ST_LATCH) else $error("Spent retries did not latch.");
  a_retry_ever: assert property (st_r == ST_TRY && tmr_done && fault_r && retries == RETRY_FOREVER
    && !abort |=> st_r == ST_OFF_WAIT) else $error("Continuous retry stopped.");
  a_gap_load: assert property (tmr_load
    |=> units_r == $past(dly_units) && ucnt_r == $past(unit_len) - 16'h0001)
    else $error("Delay timer loaded wrongly.");
  a_reload_clear: assert property (st_r == ST_LATCH && fault_clear
    |=> st_r == ST_RUN && left_r == $past(retries)) else $error("Attempt counter not reloaded on clear.");
endmodule // ut_fault_handler

// ---- logic/ut_fault_pkg.sv ----
// Package with command codes, field layout, reset values, states and carriers for the under-temperature fault logic.
package ut_fault_pkg;
  // Command codes of the two registers.
  localparam logic [7:0] CMD_UT_THRESH = 8'h53;
  localparam logic [7:0] CMD_UT_ACTION = 8'h54;
  // Reset values.
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0] ACTION_RST = 8'h00;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  // Field positions inside the action register.
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DLY_HI = 2;
  localparam int DLY_LO = 0;
  // Response codes.
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_CONTINUE = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  // Retry codes.
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Smallest units count and shortest time unit.
  localparam logic [7:0] UNITS_ONE = 8'h01;
  localparam logic [15:0] UNIT_MIN = 16'h0001;
  // Handler states.
  typedef enum logic [2:0] {ST_RUN, ST_CONT, ST_OFF_WAIT, ST_TRY, ST_LATCH} ut_state_e;
  // One register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } reg_req_s;
endpackage

// ---- logic/linear_less.sv ----
// Comparator that tells whether one linear-format value is below another.
`timescale 1ns/1ns
module linear_less (
  // Operands in linear format.
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  // Result.
  output logic a_below_b
);
  logic signed [42:0] a_fix;
  logic signed [42:0] b_fix;
  logic [4:0] a_sh;
  logic [4:0] b_sh;

  // Exponent plus sixteen is the exponent with its sign bit inverted.
  assign a_sh = {~a[15], a[14:11]};
  assign b_sh = {~b[15], b[14:11]};

  // Both values are brought to one fixed point with sixteen fraction bits.
  always_comb begin
    a_fix = 43'(signed'(a[10:0])) <<< a_sh;
    b_fix = 43'(signed'(b[10:0])) <<< b_sh;
    a_below_b = a_fix < b_fix;
  end
endmodule // linear_less

// ---- tb/reg_host.sv ----
// Register host model that issues single-cycle accesses.
`timescale 1ns/1ns
module reg_host
  import ut_fault_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Register access port.
  output reg_req_s reg_req,
  input wire logic reg_ack_r,
  input wire logic reg_err_r,
  input wire logic [15:0] reg_rdata_r
);
  // The port idles with no strobe.
  initial begin
    reg_req = '0;
  end
  // Strobe for one cycle and take the answer at the next falling edge, half a cycle after the taking edge.
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] wd,
    output logic [15:0] rd, output logic err, output logic ok);
    @(negedge clk_sys);
    reg_req = '{wr, ~wr, cmd, wd};
    @(negedge clk_sys);
    ok = reg_ack_r;
    rd = reg_rdata_r;
    err = reg_err_r;
    reg_req = '0;
  endtask
endmodule // reg_host

// ---- tb/under_temp_fault_handler_test.sv ----
// Testbench of the under-temperature fault handler.
`timescale 1ns/1ns
module under_temp_fault_handler_test
  import ut_fault_pkg::*;
();
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  reg_req_s reg_req;
  logic reg_ack_r, reg_err_r, out_en_r, fault_flag_r, latched_r, e, ok, pv;
  logic [15:0] reg_rdata_r, rd;
  logic [15:0] temp_meas = 16'h0020;
  logic [15:0] delay_unit = 16'h0001;
  logic on_cmd = 1'b1;
  logic fault_clear = 1'b0;
  logic other_fault_off = 1'b0;
  logic [31:0] seed = 32'h00007CA3;
  logic [1:0] rs;
  logic [2:0] rt, cd;
  int miscompares = 0;
  int comparisons = 0;
  int tmr, rises, lat, n;
  int fall_q[$];
  int rise_q[$];
  // Free-running clock of 4 ns.
  always #2 clk_sys = ~clk_sys;
  ut_fault_handler ut_fault_handler_i (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
    .reg_ack_r(reg_ack_r), .reg_err_r(reg_err_r), .reg_rdata_r(reg_rdata_r), .temp_meas(temp_meas),
    .delay_unit(delay_unit), .on_cmd(on_cmd), .fault_clear(fault_clear),
    .other_fault_off(other_fault_off), .out_en_r(out_en_r), .fault_flag_r(fault_flag_r),
    .latched_r(latched_r));
  reg_host reg_host_i (.clk_sys(clk_sys), .reg_req(reg_req), .reg_ack_r(reg_ack_r),
    .reg_err_r(reg_err_r), .reg_rdata_r(reg_rdata_r));
  // Pseudo-random source.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One register access with its answer compared.
  task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [15:0] x,
    input logic xe);
    reg_host_i.access(w, c, d, rd, e, ok);
    check("ack", ok, 1'b1);
    check("err", e, xe);
    if (!w) begin
      check("rdata", rd, x);
    end
  endtask
  // Main sequence: registers, then every response and retry code against the model.
  initial begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    rw(1'b0, CMD_UT_THRESH, 16'h0000, THRESH_RST, 1'b0);
    rw(1'b0, CMD_UT_ACTION, 16'h0000, {8'h00, ACTION_RST}, 1'b0);
    rw(1'b0, 8'h55, 16'h0000, 16'h0000, 1'b1);
    rw(1'b1, CMD_UT_THRESH, 16'h0010, 16'h0000, 1'b0);
    rw(1'b1, 8'h55, 16'h00FF, 16'h0000, 1'b1);
    rw(1'b0, CMD_UT_THRESH, 16'h0000, 16'h0010, 1'b0);
    temp_meas = 16'h0010;
    repeat (4) @(negedge clk_sys);
    check("flag at equal", fault_flag_r, 1'b0);
    $display("test registers done");
    for (int r = 0; r < 32; r++) begin
      rs = r[4:3];
      rt = r[2:0];
      cd = 3'(rt + rs);
      delay_unit = 16'(xs() % 2 + 1);
      tmr = (1 << cd) * delay_unit;
      rw(1'b1, CMD_UT_ACTION, {8'h00, rs, rt, cd}, 16'h0000, 1'b0);
      rw(1'b0, CMD_UT_ACTION, 16'h0000, {8'h00, rs, rt, cd}, 1'b0);
      lat = (rs == 2'h3 || (rs != 2'h0 && rt != 3'h7)) ? 1 : 0;
      rises = 0;
      fall_q = {};
      rise_q = {};
      pv = out_en_r;
      temp_meas = 16'h000F;
      // Fault seen one edge after the drop, response one edge later: sample n is taken after edge n + 1.
      for (n = 0; n < ((rt == 3'h7) ? 4 : rt + 2) * (2 * tmr + 4) + tmr + 10; n++) begin
        @(negedge clk_sys);
        if (n == 1 || (rs == 2'h1 && n == tmr)) begin
          check("out_en early", out_en_r, rs < 2'h2);
        end
        if (rs == 2'h1 && n == tmr + 1) begin
          check("continue end", out_en_r, 1'b0);
        end
        if (pv && !out_en_r) begin
          fall_q.push_back(n);
        end
        if (!pv && out_en_r) begin
          rises++;
          rise_q.push_back(n);
        end
        pv = out_en_r;
      end
      check("flag", fault_flag_r, 1'b1);
      check("latched", latched_r, lat[0]);
      if (rs == 2'h0 || rs == 2'h3 || rt != 3'h7) begin
        check("restarts", rises, (rs == 2'h0 || rs == 2'h3) ? 0 : rt);
      end else begin
        check("endless", rises >= 2, 1'b1);
      end
      // Every off time before a restart and every attempt lasts one programmed delay.
      for (int i = 0; i < rise_q.size(); i++) begin
        check("gap", rise_q[i] - fall_q[i], tmr);
        if (i + 1 < fall_q.size()) begin
          check("attempt", fall_q[i + 1] - rise_q[i], tmr);
        end
      end
      temp_meas = 16'h0020;
      // The fault must be gone before the clear, since a standing fault wins over it.
      repeat (2) @(negedge clk_sys);
      if (lat == 1 || rs == 2'h0) begin
        fault_clear = 1'b1;
        @(negedge clk_sys);
        fault_clear = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("flag clear", fault_flag_r, 1'b0);
      end else if (rs == 2'h2) begin
        other_fault_off = 1'b1;
        repeat (4) @(negedge clk_sys);
        other_fault_off = 1'b0;
        repeat (4) @(negedge clk_sys);
      end else begin
        on_cmd = 1'b0;
        repeat (4) @(negedge clk_sys);
        on_cmd = 1'b1;
        repeat (4) @(negedge clk_sys);
      end
      check("out_en back", out_en_r, 1'b1);
      check("latch clear", latched_r, 1'b0);
      $display("test response %0d retry %0d done", rs, rt);
    end
    // A reset in mid-run clears a latched fault and the registers.
    rw(1'b1, CMD_UT_ACTION, {8'h00, RESP_LATCH, RETRY_NONE, 3'h0}, 16'h0000, 1'b0);
    temp_meas = 16'h000F;
    repeat (4) @(negedge clk_sys);
    check("latched before reset", latched_r, 1'b1);
    resetn = 1'b0;
    temp_meas = 16'h0020;
    @(negedge clk_sys);
    check("latched in reset", latched_r, 1'b0);
    check("out_en in reset", out_en_r, 1'b0);
    check("flag in reset", fault_flag_r, 1'b0);
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    check("out_en after reset", out_en_r, 1'b1);
    rw(1'b0, CMD_UT_ACTION, 16'h0000, {8'h00, ACTION_RST}, 1'b0);
    rw(1'b0, CMD_UT_THRESH, 16'h0000, THRESH_RST, 1'b0);
    $display("test reset done");
    stop_test();
  end
endmodule // under_temp_fault_handler_test
